/* src/otp_read_access.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otp_read_params.svh"

module otp_read_access
  import otp_read_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        bus_reset_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             mem_rd_o,
  output logic             mem_status_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  output logic             cmd_active_o
);

  // One CRC16 step per byte, LSB first as it travels on the link
  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] d);
    logic [15:0] c;
    logic        fb;
    c  = crc_in;
    fb = 1'b0;
    for (int i = 0; i < `BYTE_W; i++)
    begin
      fb = c[0] ^ d[i];
      c  = c >> 1;
      if (fb)
        c = c ^ `CRC_POLY_REFL;
    end
    return c;
  endfunction

  // Whether a status byte exists in silicon for this device
  function automatic logic status_present(input logic [15:0] a);
    logic [8:0] pages;
    pages = `SMALL_VARIANT ? `PAGE_COUNT_SMALL : `PAGE_COUNT;
    if (`SMALL_VARIANT)
      return 1'b1;                                                           // see R22
    else if (a < `WP_REGION_END)
      return ({1'b0, a[4:0], 3'h0} < pages);                                 // see R4, R5, R6
    else if (a < `RESERVED_END)
      return 1'b0;                                                           // see R8
    else
      return ({1'b0, a[7:0]} < pages);                                       // see R7, R9
  endfunction

  state_type   state;
  state_type   next_state;
  logic [7:0]  cmd;
  logic [7:0]  addr_low;
  logic [15:0] addr;
  logic [15:0] crc;
  logic [7:0]  fetched;
  logic        fetch_present;
  logic        redir_phase;
  logic        end_after_crc;

  wire         is_status;
  wire         is_ext;
  wire [15:0]  mem_last;
  wire [15:0] status_last;
  wire [15:0]  space_last;
  wire [15:0]  redir_addr;
  wire         cmd_known;
  wire         at_last;
  wire         page_end_data;
  wire         page_end_status;
  wire         push_valid;
  wire [7:0]   push_data;
  wire         push_ready;
  wire         push_fire;
  wire         rx_take;
  wire [15:0]  crc_rx;
  wire [15:0]  crc_push;
  wire         abandon;

  // Command and address-space decoding
  assign is_status    = (cmd == `CMD_READ_STATUS);
  assign is_ext       = (cmd == `CMD_READ_EXT);
  assign mem_last     = `SMALL_VARIANT ? `MEM_LAST_SMALL : `MEM_LAST;
  assign status_last  = `SMALL_VARIANT ? `STATUS_LAST_SMALL : `STATUS_LAST;
  assign space_last   = is_status ? status_last : mem_last;
  assign redir_addr   = {`REDIR_BASE_HI, addr[12:5]};                       // see R7
  assign cmd_known    = (rx_data_i == `CMD_READ_MEM) ||                      // see R12
                        (rx_data_i == `CMD_READ_STATUS) ||                   // see R19
                        ((rx_data_i == `CMD_READ_EXT) && !`SMALL_VARIANT);   // see R22
  assign at_last         = (addr == space_last);
  assign page_end_data   = (addr[4:0] == `PAGE_END_OFS);
  assign page_end_status = (addr[2:0] == `STATUS_PAGE_END);                 // see R10

  // Memory read port; the redirection fetch goes to status space
  assign mem_rd_o     = ce_i && (state == s_fetch);
  assign mem_status_o = is_status || redir_phase;
  assign mem_addr_o   = redir_phase ? redir_addr : addr;                     // see R18
  assign cmd_active_o = (state != s_idle) && (state != s_ignore);

  // Bytes bound for the link, CRC sent inverted low byte first
  assign push_valid = (state == s_push) || (state == s_crc_lo) ||
                      (state == s_crc_hi) || (state == s_ones);
  assign push_data  = (state == s_push)   ? fetched :
                      (state == s_crc_lo) ? ~crc[7:0] :                      // see R1
                      (state == s_crc_hi) ? ~crc[15:8] :                     // see R1
                      `ONES_BYTE;                                            // see R11
  assign push_fire  = push_valid && push_ready;
  assign rx_take    = rx_valid_i && ((state == s_idle) || (state == s_addr_lo) ||
                                     (state == s_addr_hi));
  assign crc_rx     = crc_byte(crc, rx_data_i);
  assign crc_push   = crc_byte(crc, fetched);
  assign abandon    = bus_reset_i;                                           // see R25

  // Output queue toward the link; it stalls the sequencer when full
  byte_fifo #(
    .WIDTH (`BYTE_W),
    .DEPTH (`FIFO_DEPTH)
  ) tx_queue (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .flush_i     (abandon),
    .in_valid_i  (push_valid),
    .in_data_i   (push_data),
    .in_ready_o  (push_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  // Next state of the read sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      s_idle:
      begin
        if (rx_valid_i)
          next_state = cmd_known ? s_addr_lo : s_ignore;
      end
      s_addr_lo:
      begin
        if (rx_valid_i)
          next_state = s_addr_hi;                                            // see R2
      end
      s_addr_hi:
      begin
        if (rx_valid_i)
          next_state = s_fetch;                                              // see R23
      end
      s_fetch:
        next_state = s_wait;
      s_wait:
        next_state = s_push;
      s_push:
      begin
        if (push_ready)
        begin
          if (is_ext && redir_phase)
            next_state = s_crc_lo;                                           // see R13
          else if (is_ext && (page_end_data || at_last))
            next_state = s_crc_lo;                                           // see R14
          else if (is_status && (page_end_status || at_last))
            next_state = s_crc_lo;                                           // see R19
          else if (!is_ext && !is_status && at_last)
            next_state = s_crc_lo;                                           // see R11
          else
            next_state = s_fetch;
        end
      end
      s_crc_lo:
      begin
        if (push_ready)
          next_state = s_crc_hi;
      end
      s_crc_hi:
      begin
        if (push_ready)
          next_state = end_after_crc ? s_ones : s_fetch;
      end
      s_ones:
        next_state = s_ones;
      s_ignore:
        next_state = s_ignore;
      default:
        next_state = s_idle;
    endcase
  end

  // State register; bus reset drops any read in progress
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state <= s_idle;
    else if (ce_i)
      state <= abandon ? s_idle : next_state;                                // see R25
  end

  // Command and target address capture
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmd      <= 8'h00;
      addr_low <= 8'h00;
    end
    else if (ce_i && rx_take && !abandon)
    begin
      if (state == s_idle)
        cmd <= rx_data_i;
      if (state == s_addr_lo)
        addr_low <= rx_data_i;                                               // see R2
    end
  end

  // Address pointer: loaded from the target, masked to the last address of the addressed space
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      addr <= 16'h0000;
    else if (ce_i && !abandon)
    begin
      if ((state == s_addr_hi) && rx_valid_i)
        addr <= {rx_data_i, addr_low} & space_last;                          // see R3
      else if (push_fire && (state == s_push) && !redir_phase && !at_last)
        addr <= addr + 16'h0001;                                             // see R24
    end
  end

  // Redirection phase: first pass and after each data page end short of the last address
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      redir_phase <= 1'b0;
    else if (ce_i)
    begin
      if (abandon)
        redir_phase <= 1'b0;
      else if ((state == s_addr_hi) && rx_valid_i)
        redir_phase <= (cmd == `CMD_READ_EXT);                               // see R13
      else if (push_fire && (state == s_push) && is_ext)
        redir_phase <= !redir_phase && page_end_data && !at_last;            // see R15
    end
  end

  // Whether the pending check value closes the stream
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      end_after_crc <= 1'b0;
    else if (ce_i)
    begin
      if (abandon)
        end_after_crc <= 1'b0;
      else if (push_fire && (state == s_push))
        end_after_crc <= at_last && !redir_phase;                            // see R11
    end
  end

  // Fetched byte; absent status locations read as ones
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fetched       <= 8'h00;
      fetch_present <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == s_fetch)
        fetch_present <= !mem_status_o || status_present(mem_addr_o);        // see R9
      if (state == s_wait)
        fetched <= fetch_present ? mem_data_i : `ONES_BYTE;                  // see R8
    end
  end

  // CRC accumulator: zero per command, cleared after every check sent.
  // Clearing after each sent check gives both the first-pass and the
  // later-pass coverage without a separate pass flag.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      crc <= `CRC_CLEAR;
    else if (ce_i)
    begin
      if (abandon)
        crc <= `CRC_CLEAR;                                                   // see R25
      else if ((state == s_idle) && rx_valid_i)
        crc <= crc_byte(`CRC_CLEAR, rx_data_i);                              // see R20
      else if (rx_take)
        crc <= crc_rx;                                                       // see R21
      else if (push_fire && (state == s_push))
        crc <= crc_push;                                                     // see R16
      else if (push_fire && (state == s_crc_hi))
        crc <= `CRC_CLEAR;                                                   // see R17
    end
  end

endmodule
`default_nettype wire

/* src/otp_read_params.svh */
// Overview of operation
// R1: Check values use CRC16, sent inverted, low byte first.
// R2: Master sends target address low then high after the command.
// R3: Status space is 512 bytes, 000H to 1FFH, apart from data memory.
// R4: Status 000H-01FH hold data page write-protect bits, page 0 at bit 0.
// R5: Status 020H-03FH hold redirection-byte protect bits, page 0 at bit 0.
// R6: Status 040H-05FH hold a used-page bitmap kept by host software.
// R7: Redirection byte of page n sits at status address n plus 100H.
// R8: Status 60H to 0FFH are reserved without function.
// R9: Status gaps for absent pages read all ones; writes ignored.
// R10: Status pages are 8 bytes; inverted CRC16 follows each byte at xx7H.
// R11: Plain read ends with one inverted CRC16, then only ones.
// R12: Command F0H is plain read, address increments across page boundaries.
// R13: Command A5H sends redirection byte, its CRC16, then addressed data.
// R14: Extended read sends CRC16 over the page's data at each page end.
// R15: Continuing extended read sends next redirection byte, its CRC16, then data.
// R16: Page-end CRC starts cleared and covers data from the first addressed byte.
// R17: Redirection CRC covers command and address first pass, later only the byte.
// R18: Unprogrammed redirection reads FF; other values point to complement page.
// R19: Command AAH is status read with CRC16 after each 8-byte page.
// R20: Every read starts with cleared CRC; plain read CRC covers command onward.
// R21: First status CRC covers command onward; later ones a whole cleared page.
// R22: Four-page variant has one 8-byte status page and no extended read.
// R23: Address low byte first; every byte travels LSB first.
// R24: Address pointer advances after each byte sent.
// R25: Bus reset abandons the read, clears CRC history, awaits a new command.
`ifndef OTP_READ_PARAMS_SVH
`define OTP_READ_PARAMS_SVH

`define CMD_READ_MEM      8'hf0
`define CMD_READ_EXT      8'ha5
`define CMD_READ_STATUS   8'haa

`define SMALL_VARIANT     1'b0
`define PAGE_COUNT        9'h040
`define PAGE_COUNT_SMALL  9'h004
`define MEM_LAST          16'h07ff
`define MEM_LAST_SMALL    16'h007f
`define STATUS_LAST       16'h01ff
`define STATUS_LAST_SMALL 16'h0007

`define WP_REGION_END     16'h0060
`define RESERVED_END      16'h0100
`define REDIR_BASE_HI     8'h01
`define PAGE_END_OFS      5'h1f
`define STATUS_PAGE_END   3'h7

`define CRC_POLY_REFL     16'ha001
`define CRC_CLEAR         16'h0000
`define ONES_BYTE         8'hff
`define BYTE_W            8
`define FIFO_DEPTH        32

`endif

/* src/otp_read_pkg.sv */
package otp_read_pkg;

  // Read sequencer states
  typedef enum logic [3:0] {
    s_idle    = 4'h0,
    s_addr_lo = 4'h1,
    s_addr_hi = 4'h2,
    s_fetch   = 4'h3,
    s_wait    = 4'h4,
    s_push    = 4'h5,
    s_crc_lo  = 4'h6,
    s_crc_hi  = 4'h7,
    s_ones    = 4'h8,
    s_ignore  = 4'h9
  } state_type;

endpackage

/* src/byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  wire              full;
  wire              empty;
  wire              do_write;
  wire              do_read;

  // Extra pointer bit tells full from empty
  assign full        = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign empty       = (wr_ptr == rd_ptr);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = store[rd_ptr[PW-1:0]];
  assign do_write    = ce_i && in_valid_i && !full;
  assign do_read     = ce_i && out_ready_i && !empty;

  // Pointers; flush drops everything queued
  always_ff @(posedge clk_i)
  begin
    if (reset_i || (ce_i && flush_i))
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_write)
        wr_ptr <= wr_ptr + (PW+1)'(1);
      if (do_read)
        rd_ptr <= rd_ptr + (PW+1)'(1);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_i)
  begin
    if (do_write && !flush_i)
      store[wr_ptr[PW-1:0]] <= in_data_i;
  end

endmodule
`default_nettype wire

/* verif/otp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module otp_mem_model (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_status_i,
  input  wire logic [15:0] mem_addr_i,
  output logic      [7:0]  mem_data_o
);
  // Status and data spaces kept apart, chosen by the space select
  wire logic [7:0] status_byte = mem_addr_i[7:0] ^ 8'hc3;
  wire logic [7:0] data_byte   = mem_addr_i[7:0] ^ {5'h00, mem_addr_i[10:8]};

  // Answer on the enabled edge after the strobe; toggled on other enabled edges so stale use shows
  always_ff @(posedge clk_i)
    if (reset_i)
      mem_data_o <= 8'h00;
    else if (mem_rd_i)
      mem_data_o <= mem_status_i ? status_byte : data_byte;
    else if (ce_i)
      mem_data_o <= ~mem_data_o;
endmodule

`default_nettype wire

/* verif/otp_read_access_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otp_read_params.svh"

module otp_read_access_checker (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic        bus_reset_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i,
  input wire logic        mem_rd_o,
  input wire logic        mem_status_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0]  mem_data_i,
  input wire logic        cmd_active_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Fresh command byte, then both address bytes on back-to-back enabled edges
  sequence cmd_addr(code);
    ($rose(rx_valid_i) && ce_i && rx_data_i == code) ##1 (ce_i && rx_valid_i) [*2];
  endsequence

  a_read_spacing: assert property (mem_rd_o |=> !mem_rd_o [*2])
    else $error("memory reads closer than three cycles");
  a_read_enabled: assert property (mem_rd_o |-> ce_i)
    else $error("memory read without clock enable");
  a_plain_fetch:
    assert property (cmd_addr(`CMD_READ_MEM) |=> !ce_i || (mem_rd_o && !mem_status_o
      && mem_addr_o == ({$past(rx_data_i), $past(rx_data_i, 2)} & `MEM_LAST)))
    else $error("plain read fetch wrong");
  a_status_fetch:
    assert property (cmd_addr(`CMD_READ_STATUS) |=> !ce_i || (mem_rd_o && mem_status_o
      && mem_addr_o == ({$past(rx_data_i), $past(rx_data_i, 2)} & `STATUS_LAST)))
    else $error("status read fetch wrong");
  a_redir_fetch:
    assert property (cmd_addr(`CMD_READ_EXT) |=> !ce_i || (mem_rd_o && mem_status_o
      && mem_addr_o == {`REDIR_BASE_HI, 2'b00, $past(rx_data_i[2:0]), $past(rx_data_i[7:5], 2)}))
    else $error("redirection fetch wrong");
  a_reset_flush:
    assert property ((ce_i && bus_reset_i) |=> !tx_valid_o && !cmd_active_o && !mem_rd_o)
    else $error("bus reset did not abandon the read");
  a_head_holds:
    assert property ((tx_valid_o && !(ce_i && (tx_ready_i || bus_reset_i)))
      |=> tx_valid_o && $stable(tx_data_o))
    else $error("untaken byte changed or vanished");
  a_unknown_quiet:
    assert property (($rose(rx_valid_i) && ce_i && !(rx_data_i inside {`CMD_READ_MEM,
      `CMD_READ_EXT, `CMD_READ_STATUS})) |=> !cmd_active_o [*3])
    else $error("unknown command started a read");
endmodule

bind otp_read_access otp_read_access_checker u_otp_read_access_checker (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_reset_i(bus_reset_i),
  .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .mem_rd_o(mem_rd_o),
  .mem_status_o(mem_status_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
  .cmd_active_o(cmd_active_o)
);

`default_nettype wire

/* verif/otp_eprom_read_status_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otp_read_params.svh"

module otp_eprom_read_status_access_tb;
  logic        clk_i, reset_i, ce_i, bus_reset_i, rx_valid_i, tx_ready_i;
  logic [7:0]  rx_data_i, tx_data_o, mem_data_i;
  logic        tx_valid_o, mem_rd_o, mem_status_o, cmd_active_o, hold;
  logic [15:0] mem_addr_o, crc;
  logic [7:0]  exp_q [$];
  logic [15:0] st_start [5] = '{16'h0005, 16'h001d, 16'h005e, 16'h013e, 16'h01fd};
  integer      seed = 32'hbc026a13;
  int          num_errors = 0;
  int          samples_checked = 0;

  otp_read_access u_otp_read_access (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_reset_i(bus_reset_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .mem_rd_o(mem_rd_o),
    .mem_status_o(mem_status_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
    .cmd_active_o(cmd_active_o));
  otp_mem_model u_otp_mem_model (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .mem_rd_i(mem_rd_o),
    .mem_status_i(mem_status_o), .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));

  // Reflected CRC16, one bit at a time, LSB first
  function automatic logic [15:0] crc_next(logic [15:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
    return c;
  endfunction
  function automatic logic [7:0] mem_b(logic [15:0] a);
    return a[7:0] ^ {5'h00, a[10:8]};
  endfunction
  // Gaps and the reserved band read ones; only 64 pages exist
  function automatic logic [7:0] st_b(logic [15:0] a);
    logic impl;
    impl = (a < 16'h0060 && a[4:3] == 2'b00) || (a >= 16'h0100 && a < 16'h0140);
    return impl ? (a[7:0] ^ 8'hc3) : `ONES_BYTE;
  endfunction

  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_flag(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic exp_byte(input logic [7:0] b);
    exp_q.push_back(b);
    crc = crc_next(crc, b);
  endtask
  // Inverted check value, low byte first; accumulator cleared afterwards
  task automatic exp_crc;
    exp_q.push_back(~crc[7:0]);
    exp_q.push_back(~crc[15:8]);
    crc = `CRC_CLEAR;
  endtask
  task automatic exp_ones(input int n);
    repeat (n) exp_q.push_back(`ONES_BYTE);
  endtask
  task automatic enabled_edge;
    do @(posedge clk_i); while (!ce_i);
    #1;
  endtask
  task automatic send_cmd(input logic [7:0] code, input logic [15:0] addr);
    logic [7:0] b [3];
    b = '{code, addr[7:0], addr[15:8]};
    crc = `CRC_CLEAR;
    for (int i = 0; i < 3; i++)
    begin
      rx_data_i = b[i];
      rx_valid_i = 1'b1;
      crc = crc_next(crc, b[i]);
      enabled_edge();
    end
    rx_valid_i = 1'b0;
  endtask
  task automatic bus_rst;
    hold = 1'b1;
    exp_q.delete();
    bus_reset_i = 1'b1;
    enabled_edge();
    bus_reset_i = 1'b0;
    check_flag("tx_valid after bus reset", 1'b0, tx_valid_o);
    check_flag("cmd_active after bus reset", 1'b0, cmd_active_o);
    hold = 1'b0;
  endtask
  task automatic wait_drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check_flag("all bytes seen", 1'b1, exp_q.size() == 0);
    $display("test %s done", name);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Random enable on every edge; master ready at random, and only while bytes are expected
  always @(posedge clk_i)
  begin
    #1;
    ce_i = ($random(seed) & 7) != 0;
    tx_ready_i = !hold && exp_q.size() != 0 && ($random(seed) & 3) != 0;
  end

  // Oldest note against every byte the master takes
  always @(posedge clk_i)
    if (!reset_i && !bus_reset_i && ce_i && tx_valid_o === 1'b1 && tx_ready_i && exp_q.size() != 0)
      check_byte("tx byte", exp_q.pop_front(), tx_data_o);

  initial
  begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    logic [15:0] a;
    int pages;
    reset_i = 1'b1;
    ce_i = 1'b1;
    bus_reset_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    tx_ready_i = 1'b0;
    hold = 1'b1;
    crc = `CRC_CLEAR;
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    check_flag("tx_valid after reset", 1'b0, tx_valid_o);
    // Abort mid-read, then a command that must be refused
    bus_rst();
    send_cmd(`CMD_READ_MEM, 16'h0000);
    for (a = 16'h0000; a < 16'h0004; a++)
      exp_byte(mem_b(a));
    wait_drain("abort");
    bus_rst();
    send_cmd(8'h33, 16'h0000);
    repeat (8) @(posedge clk_i);
    #1;
    check_flag("cmd_active on unknown code", 1'b0, cmd_active_o);
    check_flag("tx_valid on unknown code", 1'b0, tx_valid_o);
    $display("test unknown command done");
    // Memory end with the link stalled until the buffer refuses
    bus_rst();
    hold = 1'b1;
    send_cmd(`CMD_READ_MEM, 16'h07c0);
    for (a = 16'h07c0; a <= 16'h07ff; a++)
      exp_byte(mem_b(a));
    exp_crc();
    exp_ones(3);
    repeat (300) @(posedge clk_i);
    #1;
    check_flag("stalled head", 1'b1, tx_valid_o);
    hold = 1'b0;
    wait_drain("fill and end of memory");
    // Status reads across page ends, gaps, reserved band and the top
    foreach (st_start[i])
    begin
      bus_rst();
      send_cmd(`CMD_READ_STATUS, st_start[i]);
      a = st_start[i];
      pages = 0;
      while (pages < 2 && a < 16'h0200)
      begin
        exp_byte(st_b(a));
        if (a[2:0] == `STATUS_PAGE_END)
        begin
          exp_crc();
          pages++;
        end
        a++;
      end
      if (a == 16'h0200)
        exp_ones(2);
      wait_drain("status read");
    end
    // Extended read over two page ends up to the end of memory
    bus_rst();
    send_cmd(`CMD_READ_EXT, 16'h07de);
    exp_byte(st_b(16'h013e));
    exp_crc();
    for (a = 16'h07de; a <= 16'h07ff; a++)
    begin
      exp_byte(mem_b(a));
      if (a[4:0] == `PAGE_END_OFS && a != 16'h07ff)
      begin
        exp_crc();
        exp_byte(st_b({`REDIR_BASE_HI, 2'b00, a[10:5] + 6'h01}));
        exp_crc();
      end
    end
    exp_crc();
    exp_ones(2);
    wait_drain("extended read");
    give_verdict();
  end
endmodule

`default_nettype wire
